//--- design/afp_bus_if.sv
`timescale 1ns/1ps
// Flash write/read bus between programmer and device
interface afp_bus_if;
  logic        wr_stb;    // One-cycle write strobe
  logic        rd_stb;    // One-cycle read strobe
  logic [15:0] addr;      // Word address
  logic [15:0] wdata;     // Write data
  logic [15:0] rdata;     // Read data (status)
  logic        rvalid;    // Read data valid
  modport dev  (input wr_stb, rd_stb, addr, wdata,
                output rdata, rvalid);
  modport host (output wr_stb, rd_stb, addr, wdata,
                input rdata, rvalid);
endinterface

//--- design/afp_device.sv
`timescale 1ns/1ps
module afp_device #(
  parameter int SETUP_CYCLES = afp_pkg::SETUP_CYC,
  parameter int PULSE_CYCLES = afp_pkg::PULSE_CYC
) (
  input  wire logic   sys_clk,          // System clock
  input  wire logic   rst_n,            // Sync reset, active low
  afp_bus_if.dev      bus,              // Flash bus
  input  wire logic   supply_ok,        // Program supply in range
  input  wire logic   block_locked,     // Target block lock state
  input  wire logic   cell_weak,        // Cell needs extra pulse
  output logic        pulse_en,         // Program pulse active
  output logic [15:0] array_addr,       // Internal word address
  output logic [15:0] array_data,       // Word being programmed
  output logic        mode_active       // Accelerated mode running
);
  // ---------------------------------------------------------------
  // Parameter checks; the phase timer and retry count are narrow
  // ---------------------------------------------------------------
  if (SETUP_CYCLES < 1 || SETUP_CYCLES > 256) begin : g_bad_setup
    $error("afp_device: SETUP_CYCLES out of range");
  end
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 256) begin : g_bad_pulse
    $error("afp_device: PULSE_CYCLES out of range");
  end
  if (afp_pkg::MAX_PULSES > 7) begin : g_bad_retries
    $error("afp_device: MAX_PULSES exceeds the retry counter");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_SETUP, ST_PROG, ST_PULSE, ST_VER, ST_CMP, ST_EXIT
  } afp_dev_e;

  afp_dev_e    state;
  logic [15:0] first_word_address;
  logic [15:0] cur_addr;
  logic [7:0]  timer;
  logic [2:0]  pulses;
  logic        err_supply;
  logic        err_lock;
  logic        err_fail;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  localparam int BW = afp_pkg::BLK_W;
  wire same_block = bus.addr[15:BW] == first_word_address[15:BW];
  wire exit_write = bus.wr_stb && !same_block
                    && bus.wdata == afp_pkg::DATA_EXIT;
  wire stream_wr  = bus.wr_stb && same_block;
  // Matching address steps on, other address jumps
  wire [15:0] next_addr = (bus.addr == first_word_address) ?
                          cur_addr : bus.addr;
  wire timer_done = timer == 8'h00;
  wire ver_fail   = cell_weak;

  // ---------------------------------------------------------------
  // Level inputs from outside the clock domain
  // ---------------------------------------------------------------
  logic [1:0] supply_sync;
  logic [1:0] lock_sync;
  wire        supply_good   = supply_sync[1];
  wire        target_locked = lock_sync[1];

  // Two-stage synchronisers; only the second stage feeds the sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      supply_sync <= 2'h0;
      lock_sync   <= 2'h0;
    end else begin
      supply_sync <= {supply_sync[0], supply_ok};
      lock_sync   <= {lock_sync[0], block_locked};
    end
  end

  // ---------------------------------------------------------------
  // Status byte
  // ---------------------------------------------------------------
  wire busy_stream = state inside {ST_PULSE, ST_CMP, ST_SETUP,
                                   ST_ARMED, ST_EXIT};
  wire [7:0] status_byte;
  assign status_byte[afp_pkg::SB_READY]  = (state == ST_IDLE);
  assign status_byte[6]                  = 1'b0;
  assign status_byte[5]                  = 1'b0;
  assign status_byte[afp_pkg::SB_FAIL]   = err_fail;
  assign status_byte[afp_pkg::SB_SUPPLY] = err_supply;
  assign status_byte[2]                  = 1'b0;
  assign status_byte[afp_pkg::SB_LOCK]   = err_lock;
  assign status_byte[afp_pkg::SB_STREAM] = busy_stream;

  // Reads always return status, low byte only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus.rdata  <= 16'h0000;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= bus.rd_stb;
      if (bus.rd_stb)
        bus.rdata <= {8'h00, status_byte};
    end
  end

  // ---------------------------------------------------------------
  // Sequencer; no suspend or other partition access
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      first_word_address <= 16'h0000;
      cur_addr           <= 16'h0000;
      array_data         <= 16'h0000;
      timer              <= 8'h00;
      pulses             <= 3'h0;
      err_supply         <= 1'b0;
      err_lock           <= 1'b0;
      err_fail           <= 1'b0;
    end else begin
      if (!timer_done)
        timer <= timer - 8'h01;
      unique case (state)
        ST_IDLE: begin
          if (bus.wr_stb && bus.wdata == afp_pkg::CMD_SETUP) begin
            first_word_address <= bus.addr;
            state              <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (bus.wr_stb) begin
            if (bus.wdata == afp_pkg::CMD_CONFIRM &&
                bus.addr == first_word_address) begin
              cur_addr   <= first_word_address;
              err_fail   <= 1'b0;
              err_supply <= 1'b0;
              err_lock   <= 1'b0;
              timer    <= 8'(SETUP_CYCLES - 1);
              state    <= ST_SETUP;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_SETUP: begin
          if (timer_done) begin
            err_supply <= !supply_good;
            err_lock   <= target_locked;
            state <= (!supply_good || target_locked) ? ST_IDLE : ST_PROG;
          end
        end
        ST_PROG: begin
          if (exit_write) begin
            cur_addr <= first_word_address;
            state    <= ST_VER;
          end else if (stream_wr) begin
            cur_addr   <= next_addr;
            array_data <= bus.wdata;
            timer      <= 8'(PULSE_CYCLES - 1);
            state      <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (timer_done) begin
            cur_addr <= cur_addr + 16'h0001;
            state    <= ST_PROG;
          end
        end
        ST_VER: begin
          if (exit_write) begin
            timer <= 8'(PULSE_CYCLES - 1);
            state <= ST_EXIT;
          end else if (stream_wr) begin
            cur_addr   <= next_addr;
            array_data <= bus.wdata;
            pulses     <= 3'h0;
            timer      <= 8'(PULSE_CYCLES - 1);
            state      <= ST_CMP;
          end
        end
        ST_CMP: begin
          if (timer_done) begin
            if (ver_fail && pulses != 3'(afp_pkg::MAX_PULSES)) begin
              pulses <= pulses + 3'h1;
              timer  <= 8'(PULSE_CYCLES - 1);
            end else begin
              if (ver_fail)
                err_fail <= 1'b1;
              cur_addr <= cur_addr + 16'h0001;
              state    <= ST_VER;
            end
          end
        end
        ST_EXIT: begin
          if (timer_done)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Array side outputs
  // ---------------------------------------------------------------
  assign pulse_en    = state == ST_PULSE ||
                       (state == ST_CMP && pulses != 3'h0);
  assign array_addr  = cur_addr;
  assign mode_active = state != ST_IDLE;
endmodule

//--- design/afp_host.sv
`timescale 1ns/1ps
module afp_host #(
  parameter int WORDS_MAX = 256
) (
  input  wire logic   sys_clk,     // System clock
  input  wire logic   rst_n,       // Sync reset, active low
  afp_bus_if.host     bus,         // Flash bus
  input  wire logic   start,       // Begin a run, one-cycle pulse
  input  wire logic [15:0] base,   // First word address
  input  wire logic [15:0] nwords, // Word count
  input  wire logic [15:0] src,    // Data word for index word_idx
  output logic [15:0] word_idx,    // Index of word requested
  output logic        done,        // Run finished, one-cycle pulse
  output logic [7:0]  final_status // Status after exit or setup fault
);
  // A run never holds more words than one block has
  if (WORDS_MAX < 1 || WORDS_MAX > (1 << afp_pkg::BLK_W)) begin : g_bad_words
    $error("afp_host: WORDS_MAX out of range");
  end

  typedef enum logic [3:0] {
    H_IDLE, H_SETUP, H_CONF, H_POLL, H_WAIT, H_CHECK, H_WRITE, H_EXIT
  } afp_host_e;

  afp_host_e   state;
  logic        verify;     // Second pass
  logic        setup_wait; // Polling for setup end
  logic        exit_wait;  // Polling for exit end
  logic [15:0] out_addr;   // Outside-block address
  logic [7:0]  last_stat;

  wire [7:0] st = bus.rdata[7:0];
  // Stop at the requested count or at the block's capacity
  wire last_word = (word_idx == nwords) || (word_idx == 16'(WORDS_MAX));

  // Bus drive from state
  assign bus.wr_stb = state inside {H_SETUP, H_CONF, H_WRITE, H_EXIT};
  assign bus.rd_stb = state == H_POLL;
  // Program pass steps the address, verify pass holds the first one
  assign bus.addr   = (state == H_EXIT) ? out_addr :
                      verify ? base : base + word_idx;
  assign bus.wdata  = (state == H_SETUP) ? afp_pkg::CMD_SETUP :
                      (state == H_CONF)  ? afp_pkg::CMD_CONFIRM :
                      (state == H_EXIT)  ? afp_pkg::DATA_EXIT : src;

  // Programming sequence; host never sends read-status command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state        <= H_IDLE;
      verify       <= 1'b0;
      setup_wait   <= 1'b0;
      exit_wait    <= 1'b0;
      word_idx     <= 16'h0000;
      done         <= 1'b0;
      final_status <= 8'h00;
      last_stat    <= 8'h00;
      out_addr     <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (state)
        H_IDLE: if (start) begin
          out_addr   <= base ^ (16'h0001 << afp_pkg::BLK_W);
          word_idx   <= 16'h0000;
          verify     <= 1'b0;
          exit_wait  <= 1'b0;
          state      <= H_SETUP;
        end
        H_SETUP: state <= H_CONF;
        H_CONF: begin
          setup_wait <= 1'b1;
          state      <= H_POLL;
        end
        H_POLL: state <= H_WAIT;
        H_WAIT: if (bus.rvalid) begin
          last_stat <= st;
          state     <= H_CHECK;
        end
        H_CHECK: begin
          if (setup_wait) begin
            if (last_stat[afp_pkg::SB_SUPPLY] ||
                last_stat[afp_pkg::SB_LOCK]) begin
              final_status <= last_stat;
              done         <= 1'b1;
              state        <= H_IDLE;
            end else if (!last_stat[afp_pkg::SB_READY] &&
                         !last_stat[afp_pkg::SB_STREAM]) begin
              setup_wait <= 1'b0;
              state      <= H_WRITE;
            end else begin
              state <= H_POLL;
            end
          end else if (exit_wait) begin
            if (last_stat[afp_pkg::SB_READY]) begin
              final_status <= last_stat;
              done         <= 1'b1;
              state        <= H_IDLE;
            end else begin
              state <= H_POLL;
            end
          end else if (last_stat[afp_pkg::SB_STREAM]) begin
            state <= H_POLL;
          end else begin
            state <= last_word ? H_EXIT : H_WRITE;
          end
        end
        H_WRITE: begin
          word_idx <= word_idx + 16'h0001;
          state    <= H_POLL;
        end
        H_EXIT: begin
          word_idx <= 16'h0000;
          if (verify)
            exit_wait <= 1'b1;
          verify <= 1'b1;
          state  <= H_POLL;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

//--- design/afp_pkg.sv
// Behaviour
// - Setup 30h then D0h at first word address
// - Host unlocks target block before setup (this host does not; a locked block sets bit 1)
// - Status bit 7 low means setup ready
// - Setup faults set supply or lock bit
// - Host polls bit 0 before each write
// - Program writes carry data words
// - Bit 0 high while pulse applied
// - Device auto-increments word address per word
// - Host keeps block base address constant (this host steps it in the program pass)
// - FFFFh outside block ends program phase
// - Bit 0 low means verify word accepted
// - Host replays verify stream in same order
// - Verify re-pulses unprogrammed bits
// - Bit 4 flags any failed word
// - FFFFh outside block ends verify phase
// - Bit 7 high once exit done
// - After exit any command accepted
// - All reads return status during mode
// - Matching address goes sequential, else jump
// - No other-partition reads, no suspend
package afp_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 16;
  localparam int          BLK_W        = 8;    // Word offset bits in block
  localparam logic [15:0] CMD_SETUP    = 16'h0030;
  localparam logic [15:0] CMD_CONFIRM  = 16'h00D0;
  localparam logic [15:0] CMD_RDSTAT   = 16'h0070;
  localparam logic [15:0] DATA_EXIT    = 16'hFFFF;
  localparam int          SB_STREAM    = 0;
  localparam int          SB_LOCK      = 1;
  localparam int          SB_SUPPLY    = 3;
  localparam int          SB_FAIL      = 4;
  localparam int          SB_READY     = 7;
  localparam int          SETUP_NS     = 200;
  localparam int          PULSE_NS     = 100;
  localparam int          CLK_NS       = 10;
  localparam int          SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          MAX_PULSES   = 4;
endpackage

//--- verif/afp_bus_checker.sv
`timescale 1ns/1ps
module afp_bus_checker #(
  parameter int SETUP_CYCLES = afp_pkg::SETUP_CYC,
  parameter int PULSE_CYCLES = afp_pkg::PULSE_CYC
) (
  input wire logic        sys_clk,     // System clock
  input wire logic        rst_n,       // Sync reset, active low
  input wire logic        wr_stb,      // Write strobe
  input wire logic        rd_stb,      // Read strobe
  input wire logic [15:0] wdata,       // Write data
  input wire logic [15:0] rdata,       // Status read data
  input wire logic        rvalid,      // Read data valid
  input wire logic        pulse_en,    // Program pulse active
  input wire logic        mode_active  // Accelerated mode running
);
  // All checks here run on the system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  int   run_len;
  logic seen_ready;

  // Length of the current unbroken pulse run
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !pulse_en) begin
      run_len <= 0;
    end else begin
      run_len <= run_len + 1;
    end
  end

  // A ready status seen since the last write
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wr_stb) begin
      seen_ready <= 1'b0;
    end else if (rvalid && (rdata[afp_pkg::SB_STREAM] == 1'b0)) begin
      seen_ready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  a_read_answered: assert property (rd_stb |=> rvalid)
    else $error("read strobe not answered next cycle");
  a_answer_has_cause: assert property (rvalid |-> $past(rd_stb))
    else $error("read valid without a read strobe");
  a_status_low_byte: assert property (rvalid |-> rdata[15:8] == 8'h00)
    else $error("status upper byte not zero");
  a_idle_ready: assert property (!mode_active && rd_stb |=>
    rdata[afp_pkg::SB_READY] == 1'b1 && rdata[afp_pkg::SB_STREAM] == 1'b0)
    else $error("idle status not ready");
  a_mode_busy: assert property (mode_active && rd_stb |=>
    rdata[afp_pkg::SB_READY] == 1'b0)
    else $error("ready bit high while mode active");
  a_pulse_busy: assert property (pulse_en && rd_stb |=>
    rdata[afp_pkg::SB_STREAM] == 1'b1)
    else $error("stream bit low during a pulse");
  a_pulse_length: assert property ($rose(pulse_en) |-> pulse_en[*8])
    else $error("program pulse too short");
  a_pulse_bounded: assert property (pulse_en |->
    run_len < PULSE_CYCLES * (afp_pkg::MAX_PULSES + 1))
    else $error("pulse run exceeds retry limit");
  a_setup_quiet: assert property (wr_stb && mode_active &&
    wdata == afp_pkg::CMD_CONFIRM |=> !pulse_en[*8])
    else $error("pulse during setup");
  a_write_after_poll: assert property (wr_stb && mode_active &&
    wdata != afp_pkg::CMD_CONFIRM |-> seen_ready && !pulse_en)
    else $error("stream write without ready poll");

  c_mode_entered: cover property ($rose(mode_active));
  c_mode_left: cover property ($fell(mode_active));
  c_fail_seen: cover property (rvalid && rdata[afp_pkg::SB_FAIL]);
  c_lock_seen: cover property (rvalid && rdata[afp_pkg::SB_LOCK]);
endmodule

//--- verif/test_enhanced_factory_program_seq.sv
`timescale 1ns/1ps
module test_enhanced_factory_program_seq;
  logic        sys_clk      = 1'b0;
  logic        rst_n        = 1'b0;
  logic        start        = 1'b0;
  logic [15:0] base         = 16'h0000;
  logic [15:0] nwords       = 16'h0000;
  logic        supply_ok    = 1'b1;
  logic        block_locked = 1'b0;
  logic        cell_weak    = 1'b0;
  logic        pulse_d      = 1'b0;
  logic        track        = 1'b0;
  logic [15:0] src;
  logic [15:0] word_idx;
  logic        done;
  logic [7:0]  final_status;
  logic        pulse_en;
  logic [15:0] array_addr;
  logic [15:0] array_data;
  logic        mode_active;
  int          pcount       = 0;
  int          err_count    = 0;
  int          cmp_count    = 0;

  afp_bus_if bus ();

  // Clock and word source derived from the requested index
  always #5 sys_clk = ~sys_clk;
  assign src = 16'hA500 + word_idx;

  afp_device afp_device_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.dev),
    .supply_ok(supply_ok), .block_locked(block_locked),
    .cell_weak(cell_weak), .pulse_en(pulse_en), .array_addr(array_addr),
    .array_data(array_data), .mode_active(mode_active));
  afp_host afp_host_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.host), .start(start),
    .base(base), .nwords(nwords), .src(src), .word_idx(word_idx),
    .done(done), .final_status(final_status));
  afp_bus_checker afp_bus_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_stb(bus.wr_stb),
    .rd_stb(bus.rd_stb), .wdata(bus.wdata), .rdata(bus.rdata),
    .rvalid(bus.rvalid), .pulse_en(pulse_en), .mode_active(mode_active));

  // ----------------------------------------
  // Comparison and closing report
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h",
               $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Each first-pass pulse must hit the next word with its data
  always @(posedge sys_clk) begin
    pulse_d <= pulse_en;
    if (rst_n && track && pulse_en && !pulse_d) begin
      check(array_addr, base + 16'(pcount), "word address");
      check(array_data, 16'hA500 + 16'(pcount), "word data");
      pcount <= pcount + 1;
    end
  end

  // One full run of setup, stream, verify and exit
  task automatic run(input logic [15:0] b, input logic [15:0] n,
                     input logic lk, input logic sp, input logic wk,
                     input logic [7:0] exp);
    int i;
    @(posedge sys_clk);
    base <= b;
    nwords <= n;
    block_locked <= lk;
    supply_ok <= sp;
    cell_weak <= wk;
    track <= !wk && !lk && sp;
    pcount <= 0;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (i = 0; i < 20000; i++) begin
      @(posedge sys_clk);
      if (done === 1'b1) break;
    end
    if (i == 20000) begin
      err_count++;
      $display("CHECK FAILED at %0t: run never finished", $time);
      test_done();
    end
    #1;
    check({8'h00, final_status}, {8'h00, exp}, "final status");
    check({15'h0000, mode_active}, 16'h0000, "mode idle");
    if (track) check(16'(pcount), n, "pulse count");
    $display("Test of %0d words at %h ended", n, b);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    run(16'h1200, 16'h0004, 1'b0, 1'b1, 1'b0, 8'h80);
    run(16'h1200, 16'h0003, 1'b0, 1'b1, 1'b1, 8'h90);
    run(16'h2200, 16'h0002, 1'b1, 1'b1, 1'b0, 8'h82);
    run(16'h2200, 16'h0002, 1'b0, 1'b0, 1'b0, 8'h88);
    run(16'h34FC, 16'h0004, 1'b0, 1'b1, 1'b0, 8'h80);
    test_done();
  end
endmodule
